// ==== rtl/sicg_clock_guard.sv ====
// System integrity clock guard: fallback switching, supply warning and reset-source flags
`timescale 1ns/10ps
// How it works
// RULE1 - Spikes on the main oscillator are filtered only while the PLL is enabled.
// RULE2 - Losing the main oscillator switches the CPU clock to the fallback oscillator.
// RULE3 - Main oscillator recovery switches the CPU clock back automatically.
// RULE4 - Fallback running sets the fallback flag; enabled, it raises a clock-fail interrupt.
// RULE5 - Wait mode changes nothing; both interrupts wake the device from wait.
// RULE6 - Halt disables guard and fallback, freezes the register, resumes afterwards.
// RULE7 - Interrupts need their own enable and a cleared global mask.
// RULE8 - Neither event can wake the device from halt.
// RULE9 - Bit 6 enables supply-warning interrupt on flag toggles; cleared on service.
// RULE10 - Bit 5 reads the supply-low comparator: 1 below, 0 above threshold.
// RULE11 - Bit 4 set on undervoltage reset, cleared by writing zero.
// RULE12 - Software writes zero to reserved bit 3.
// RULE13 - Bit 2 enables clock-fail interrupt; no effect with guard disabled.
// RULE14 - Bit 1 set on fallback; read clears it after recovery; zero if guard off.
// RULE15 - Bit 0 set on watchdog reset; cleared by writing zero or undervoltage reset.
// RULE16 - Flags encode last reset: pin 00, watchdog 01, undervoltage 1x.
// RULE17 - Undervoltage flag survives later pin and watchdog resets.
// RULE18 - After reset enables and reserved bit read zero.
// RULE19 - Supply warning works only with undervoltage detection enabled.
// RULE20 - Clock-fail request holds while flag and enable are both set.
module sicg_clock_guard
  import sicg_pkg::*;
#(
  parameter int LOSS_CYCLES = MAIN_LOSS_CYCLES,
  parameter int GOOD_EDGES = RECOVER_EDGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_WIDTH-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_WIDTH-1:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire logic mainOscSample,
  input wire logic pllEnable,
  input wire logic supplyBelowThreshold,
  input wire sicg_reset_cause_type resetCause,
  input wire sicg_cpu_mode_type cpuMode,
  output logic [1:0] clockSource,
  output logic cpuClockFiltered,
  output logic clockFailIrq,
  output logic supplyWarningIrq,
  output logic wakeFromWait
);
  // ***********************************************
  // State
  // ***********************************************
  sicg_guard_state_type state, next_state;
  logic supplyIrqEnable, next_supplyIrqEnable;
  logic clockIrqEnable, next_clockIrqEnable;
  logic supplyLow, next_supplyLow;
  logic uvFlag, next_uvFlag;
  logic wdFlag, next_wdFlag;
  logic fallbackFlag, next_fallbackFlag;
  logic supplyPending, next_supplyPending;
  logic guardEnable, next_guardEnable;
  logic uvEnable, next_uvEnable;
  logic strapDone, next_strapDone;
  logic busy, next_busy, next_waitrequest;
  logic [DATA_WIDTH-1:0] next_readdata;
  logic [1:0] next_response;
  logic [1:0] next_clockSource;
  logic next_clockFailIrq, next_supplyWarningIrq, next_wakeFromWait;
  logic mainLost, filtOsc, watchEnable;
  logic regAccess, regWrite, regRead;

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
    is_mapped = (a == ADDR_INTEGRITY_CTRL_STATUS) || (a == ADDR_GUARD_CONFIG) || (a == ADDR_IRQ_ACK);
  endfunction

  function automatic logic [7:0] status_byte(input logic sie, input logic sl, input logic uv,
                                             input logic cie, input logic fb, input logic wd);
    status_byte = INTEGRITY_RESET_VALUE;
    status_byte[BIT_SUPPLY_WARNING_IRQ_ENABLE] = sie;
    status_byte[BIT_SUPPLY_LOW_FLAG] = sl;
    status_byte[BIT_UNDERVOLTAGE_RESET_FLAG] = uv;
    status_byte[BIT_CLOCK_FAIL_IRQ_ENABLE] = cie;
    status_byte[BIT_FALLBACK_ACTIVE_FLAG] = fb;
    status_byte[BIT_WATCHDOG_RESET_FLAG] = wd;
  endfunction

  // Guard monitor stops in halt and when disabled by configuration
  assign watchEnable = guardEnable && !cpuMode.haltMode; // [RULE6]

  sicg_edge_watch #(
    .LOSS_CYCLES(LOSS_CYCLES),
    .GOOD_EDGES(GOOD_EDGES)
  ) u_watch (
    .clk(clk),
    .rst(rst),
    .mainOscSample(mainOscSample),
    .pllEnable(pllEnable),
    .enable(watchEnable),
    .mainLost(mainLost),
    .filteredOsc(filtOsc)
  );

  // Bus access is taken on a cycle busy is clear; answer a cycle later
  assign regAccess = (read || write) && !busy;
  assign regWrite = write && !busy;
  assign regRead = read && !busy;

  // ***********************************************
  // Next-state logic
  // ***********************************************
  always_comb begin
    next_state = state;
    next_supplyIrqEnable = supplyIrqEnable;
    next_clockIrqEnable = clockIrqEnable;
    next_uvFlag = uvFlag;
    next_wdFlag = wdFlag;
    next_fallbackFlag = fallbackFlag;
    next_supplyPending = supplyPending;
    next_guardEnable = guardEnable;
    next_uvEnable = uvEnable;
    next_strapDone = 1'b1;
    next_busy = regAccess;
    // Waitrequest drops for the one cycle in which the registered answer stands
    next_waitrequest = !regAccess;
    next_readdata = '0;
    next_response = 2'h0;
    next_supplyLow = supplyLow;
    // Clock source state machine
    case (state)
      GUARD_MAIN: begin
        if (cpuMode.haltMode) begin
          next_state = GUARD_HALTED; // [RULE6]
        end else if (mainLost) begin
          next_state = GUARD_FALLBACK; // [RULE2]
        end
      end
      GUARD_FALLBACK: begin
        if (cpuMode.haltMode) begin
          next_state = GUARD_HALTED; // [RULE6]
        end else if (!mainLost) begin
          next_state = GUARD_MAIN; // [RULE3]
        end
      end
      GUARD_HALTED: begin
        if (!cpuMode.haltMode) begin
          next_state = GUARD_MAIN;
        end
      end
      default: begin
        next_state = GUARD_MAIN;
      end
    endcase
    if (!guardEnable) begin
      next_state = cpuMode.haltMode ? GUARD_HALTED : GUARD_MAIN;
    end
    // Reset-source flags caught once after reset release
    if (!strapDone) begin
      if (resetCause.uvReset) begin
        next_uvFlag = 1'b1; // [RULE11] [RULE16]
        next_wdFlag = 1'b0; // [RULE15]
      end else if (resetCause.wdogReset) begin
        next_wdFlag = 1'b1; // [RULE15] [RULE16] [RULE17]
      end
    end
    if (!cpuMode.haltMode) begin
      // Supply comparator followed only with undervoltage detection on
      next_supplyLow = uvEnable ? supplyBelowThreshold : 1'b0; // [RULE10] [RULE19]
      if (next_state == GUARD_FALLBACK && guardEnable) begin
        next_fallbackFlag = 1'b1; // [RULE4]
      end
    end
    if (regAccess && address == ADDR_INTEGRITY_CTRL_STATUS) begin
      if (regRead) begin
        next_readdata[7:0] = status_byte(supplyIrqEnable, supplyLow, uvFlag,
                                         clockIrqEnable, fallbackFlag, wdFlag);
        // Read clears fallback flag only once main clock is back
        if (!cpuMode.haltMode && state != GUARD_FALLBACK && next_state != GUARD_FALLBACK) begin
          next_fallbackFlag = 1'b0; // [RULE14]
        end
      end else if (regWrite && byteenable[0] && !cpuMode.haltMode) begin
        next_supplyIrqEnable = writedata[BIT_SUPPLY_WARNING_IRQ_ENABLE]; // [RULE9]
        next_clockIrqEnable = writedata[BIT_CLOCK_FAIL_IRQ_ENABLE]; // [RULE13]
        // Flags only cleared by writing zero, hardware set wins
        if (!writedata[BIT_UNDERVOLTAGE_RESET_FLAG] && !(!strapDone && resetCause.uvReset)) begin
          next_uvFlag = 1'b0; // [RULE11]
        end
        if (!writedata[BIT_WATCHDOG_RESET_FLAG] && !(!strapDone && resetCause.wdogReset)) begin
          next_wdFlag = 1'b0; // [RULE15]
        end
      end
    end
    if (regAccess && address == ADDR_GUARD_CONFIG) begin
      if (regRead) begin
        next_readdata[BIT_CFG_GUARD_ENABLE] = guardEnable;
        next_readdata[BIT_CFG_UNDERVOLTAGE_ENABLE] = uvEnable;
      end else if (byteenable[0]) begin
        next_guardEnable = writedata[BIT_CFG_GUARD_ENABLE];
        next_uvEnable = writedata[BIT_CFG_UNDERVOLTAGE_ENABLE];
      end
    end
    // Pending supply warning: set by a toggle, cleared on service entry, set wins
    if (regWrite && address == ADDR_IRQ_ACK && byteenable[0] && writedata[BIT_ACK_SUPPLY_WARNING]) begin
      next_supplyPending = 1'b0; // [RULE9]
    end
    if (supplyIrqEnable && uvEnable && next_supplyLow != supplyLow) begin
      next_supplyPending = 1'b1; // [RULE9] [RULE19]
    end
    if (!guardEnable) begin
      next_fallbackFlag = 1'b0; // [RULE14]
    end
    if (regAccess && !is_mapped(address)) begin
      next_response = 2'h2;
    end
    // Outputs
    case (next_state)
      GUARD_FALLBACK: next_clockSource = CLOCK_SRC_FALLBACK;
      GUARD_HALTED: next_clockSource = CLOCK_SRC_STOPPED;
      default: next_clockSource = CLOCK_SRC_MAIN;
    endcase
    next_clockFailIrq = next_fallbackFlag && next_clockIrqEnable && next_guardEnable
                        && !cpuMode.globalMask; // [RULE7] [RULE13] [RULE20]
    next_supplyWarningIrq = next_supplyPending && next_supplyIrqEnable && !cpuMode.globalMask; // [RULE7]
    // Wake applies to wait mode only, never halt
    next_wakeFromWait = cpuMode.waitMode && !cpuMode.haltMode
                        && (next_clockFailIrq || next_supplyWarningIrq); // [RULE5] [RULE8]
  end

  // ***********************************************
  // Registers
  // ***********************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= GUARD_MAIN;
      supplyIrqEnable <= INTEGRITY_RESET_VALUE[BIT_SUPPLY_WARNING_IRQ_ENABLE]; // [RULE18]
      clockIrqEnable <= INTEGRITY_RESET_VALUE[BIT_CLOCK_FAIL_IRQ_ENABLE]; // [RULE18]
      supplyLow <= INTEGRITY_RESET_VALUE[BIT_SUPPLY_LOW_FLAG];
      wdFlag <= 1'b0;
      fallbackFlag <= INTEGRITY_RESET_VALUE[BIT_FALLBACK_ACTIVE_FLAG];
      supplyPending <= 1'b0;
      guardEnable <= GUARD_CONFIG_RESET_VALUE[BIT_CFG_GUARD_ENABLE];
      uvEnable <= GUARD_CONFIG_RESET_VALUE[BIT_CFG_UNDERVOLTAGE_ENABLE];
      strapDone <= 1'b0;
      busy <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= '0;
      response <= 2'h0;
      clockSource <= CLOCK_SRC_MAIN;
      cpuClockFiltered <= 1'b0;
      clockFailIrq <= 1'b0;
      supplyWarningIrq <= 1'b0;
      wakeFromWait <= 1'b0;
    end else begin
      state <= next_state;
      supplyIrqEnable <= next_supplyIrqEnable;
      clockIrqEnable <= next_clockIrqEnable;
      supplyLow <= next_supplyLow;
      wdFlag <= next_wdFlag;
      fallbackFlag <= next_fallbackFlag;
      supplyPending <= next_supplyPending;
      guardEnable <= next_guardEnable;
      uvEnable <= next_uvEnable;
      strapDone <= next_strapDone;
      busy <= next_busy;
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      response <= next_response;
      clockSource <= next_clockSource;
      cpuClockFiltered <= filtOsc; // [RULE1]
      clockFailIrq <= next_clockFailIrq;
      supplyWarningIrq <= next_supplyWarningIrq;
      wakeFromWait <= next_wakeFromWait;
    end
  end

  // No reset: the flag outlives pin and watchdog resets; power-up comes by undervoltage reset
  always_ff @(posedge clk) begin
    uvFlag <= next_uvFlag; // [RULE17]
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  sequence s_lostSeen;
    mainLost && guardEnable && !cpuMode.haltMode;
  endsequence
  property p_fallback;
    @(posedge clk) disable iff (rst) s_lostSeen |=> clockSource == CLOCK_SRC_FALLBACK;
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback not selected"); // [RULE2]
  property p_return;
    @(posedge clk) disable iff (rst) (state == GUARD_FALLBACK && !mainLost && !cpuMode.haltMode)
      |=> clockSource == CLOCK_SRC_MAIN;
  endproperty
  a_return: assert property (p_return) else $error("main clock not restored"); // [RULE3]
  property p_flagSet;
    @(posedge clk) disable iff (rst) (state == GUARD_FALLBACK && guardEnable) |-> fallbackFlag;
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("fallback flag missing"); // [RULE4]
  property p_haltStop;
    @(posedge clk) disable iff (rst) cpuMode.haltMode |=> clockSource == CLOCK_SRC_STOPPED && !wakeFromWait;
  endproperty
  a_haltStop: assert property (p_haltStop) else $error("halt not honoured"); // [RULE6] [RULE8]
  property p_masked;
    @(posedge clk) disable iff (rst) $past(cpuMode.globalMask) |-> !clockFailIrq && !supplyWarningIrq;
  endproperty
  a_masked: assert property (p_masked) else $error("interrupt while masked"); // [RULE7]
  property p_guardOff;
    @(posedge clk) disable iff (rst) !guardEnable |=> !fallbackFlag && !clockFailIrq;
  endproperty
  a_guardOff: assert property (p_guardOff) else $error("guard off but flag set"); // [RULE14]
  property p_cfIrqHold;
    @(posedge clk) disable iff (rst)
      clockFailIrq == (fallbackFlag && clockIrqEnable && guardEnable && !$past(cpuMode.globalMask));
  endproperty
  a_cfIrqHold: assert property (p_cfIrqHold) else $error("clock-fail request dropped"); // [RULE20]
  property p_supplyOff;
    @(posedge clk) disable iff (rst) !uvEnable && !cpuMode.haltMode |=> !supplyLow;
  endproperty
  a_supplyOff: assert property (p_supplyOff) else $error("supply flag without detection"); // [RULE19]
  property p_uvKeep;
    @(posedge clk) disable iff (rst) (uvFlag && !regWrite) |=> uvFlag;
  endproperty
  a_uvKeep: assert property (p_uvKeep) else $error("undervoltage flag lost"); // [RULE17]
endmodule // sicg_clock_guard

// ==== rtl/sicg_edge_watch.sv ====
// Main oscillator activity monitor with spike filtering
`timescale 1ns/10ps
module sicg_edge_watch
  import sicg_pkg::*;
#(
  parameter int LOSS_CYCLES = MAIN_LOSS_CYCLES,
  parameter int GOOD_EDGES = RECOVER_EDGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mainOscSample,
  input wire logic pllEnable,
  input wire logic enable,
  output logic mainLost,
  output logic filteredOsc
);
  localparam int CW = $clog2(LOSS_CYCLES + 1);
  localparam int EW = $clog2(GOOD_EDGES + 1);
  logic [2:0] hist;
  logic [2:0] next_hist;
  logic [CW-1:0] idleCnt;
  logic [CW-1:0] next_idleCnt;
  logic [EW-1:0] goodCnt;
  logic [EW-1:0] next_goodCnt;
  logic next_mainLost;
  logic next_filteredOsc;
  logic majority;
  logic edgeSeen;

  always_comb begin
    next_hist = {hist[1:0], mainOscSample};
    majority = (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);
    // Isolated one-sample spikes are voted away only with the PLL running
    next_filteredOsc = pllEnable ? majority : hist[0];
    edgeSeen = next_filteredOsc != filteredOsc;
    next_idleCnt = idleCnt;
    next_goodCnt = goodCnt;
    next_mainLost = mainLost;
    if (!enable) begin
      next_idleCnt = '0;
      next_goodCnt = '0;
      next_mainLost = 1'b0;
    end else if (edgeSeen) begin
      next_idleCnt = '0;
      if (mainLost) begin
        next_goodCnt = goodCnt + 1'b1;
        if (goodCnt == EW'(GOOD_EDGES - 1)) begin
          next_mainLost = 1'b0;
          next_goodCnt = '0;
        end
      end
    end else if (idleCnt == CW'(LOSS_CYCLES - 1)) begin
      next_mainLost = 1'b1;
      next_goodCnt = '0;
    end else begin
      next_idleCnt = idleCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist <= '0;
      idleCnt <= '0;
      goodCnt <= '0;
      mainLost <= 1'b0;
      filteredOsc <= 1'b0;
    end else begin
      hist <= next_hist;
      idleCnt <= next_idleCnt;
      goodCnt <= next_goodCnt;
      mainLost <= next_mainLost;
      filteredOsc <= next_filteredOsc;
    end
  end
endmodule // sicg_edge_watch

// ==== rtl/sicg_pkg.sv ====
// Package for the system integrity clock guard: register map, fields and timing constants
package sicg_pkg;
  // ***********************************************
  // Register bus map (word offsets as byte addresses)
  // ***********************************************
  localparam logic [3:0] ADDR_INTEGRITY_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_GUARD_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ACK = 4'h8;
  localparam int ADDR_WIDTH = 4;
  localparam int DATA_WIDTH = 32;
  // ***********************************************
  // Field positions of the integrity control/status register
  // ***********************************************
  localparam int BIT_WATCHDOG_RESET_FLAG = 0;
  localparam int BIT_FALLBACK_ACTIVE_FLAG = 1;
  localparam int BIT_CLOCK_FAIL_IRQ_ENABLE = 2;
  localparam int BIT_RESERVED = 3;
  localparam int BIT_UNDERVOLTAGE_RESET_FLAG = 4;
  localparam int BIT_SUPPLY_LOW_FLAG = 5;
  localparam int BIT_SUPPLY_WARNING_IRQ_ENABLE = 6;
  localparam logic [7:0] INTEGRITY_RESET_VALUE = 8'h00;
  // Bits of the guard configuration register
  localparam int BIT_CFG_GUARD_ENABLE = 0;
  localparam int BIT_CFG_UNDERVOLTAGE_ENABLE = 1;
  localparam logic [1:0] GUARD_CONFIG_RESET_VALUE = 2'h3;
  // Bit of the interrupt acknowledge register (write 1 = supply warning ISR entered)
  localparam int BIT_ACK_SUPPLY_WARNING = 0;
  // ***********************************************
  // Clock detection timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MAIN_LOSS_TIME_NS = 1000;
  localparam int MAIN_LOSS_CYCLES = (MAIN_LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_EDGES = 4;
  localparam logic [1:0] CLOCK_SRC_MAIN = 2'h0;
  localparam logic [1:0] CLOCK_SRC_FALLBACK = 2'h1;
  localparam logic [1:0] CLOCK_SRC_STOPPED = 2'h2;

  typedef enum {GUARD_MAIN, GUARD_FALLBACK, GUARD_HALTED} sicg_guard_state_type;

  typedef struct packed {
    logic wdogReset;
    logic uvReset;
    logic extReset;
  } sicg_reset_cause_type;

  typedef struct packed {
    logic waitMode;
    logic haltMode;
    logic globalMask;
  } sicg_cpu_mode_type;
endpackage

// ==== test/sicg_osc_model.sv ====
// Main oscillator model: a slow toggling source that can stop and inject spikes
`timescale 1ns/10ps
module sicg_osc_model (
  input wire logic clk,
  input wire logic run,
  input wire logic spike,
  output logic mainOscSample
);
  logic level = 1'b0;
  logic [1:0] div = 2'h0;
  always_ff @(posedge clk) begin
    div <= div + 2'h1;
    if (run && div == 2'h3) begin
      level <= !level;
    end
  end
  // A stopped source holds its level; a spike inverts the line for one cycle
  assign mainOscSample = level ^ spike;
endmodule // sicg_osc_model

// ==== test/system_integrity_clock_guard_tb.sv ====
// Self-checking testbench for the system integrity clock guard
`timescale 1ns/10ps
module system_integrity_clock_guard_tb
  import sicg_pkg::*;
;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] rb;
    logic [1:0] rs;
  } sicg_row_type;
  logic clk, rst, read, write, pllEnable, supplyBelowThreshold, oscRun, oscSpike;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [1:0] response, clockSource, r;
  logic waitrequest, mainOscSample, cpuClockFiltered, clockFailIrq, supplyWarningIrq, wakeFromWait, v, seen;
  sicg_reset_cause_type resetCause;
  sicg_cpu_mode_type cpuMode;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  sicg_row_type rows [5] = '{'{4'h0, 8'h44, 8'h44, 2'h0}, '{4'h0, 8'h20, 8'h00, 2'h0},
    '{4'h0, 8'h04, 8'h04, 2'h0}, '{4'hC, 8'h40, 8'h04, 2'h2}, '{4'h0, 8'h44, 8'h44, 2'h0}};
  sicg_reset_cause_type rc [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
  logic [7:0] rx [4] = '{8'h01, 8'h10, 8'h10, 8'h11};

  sicg_clock_guard #(.LOSS_CYCLES(8), .GOOD_EDGES(4)) DUT (
    .clk(clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .response(response),
    .mainOscSample(mainOscSample),
    .pllEnable(pllEnable),
    .supplyBelowThreshold(supplyBelowThreshold),
    .resetCause(resetCause),
    .cpuMode(cpuMode),
    .clockSource(clockSource),
    .cpuClockFiltered(cpuClockFiltered),
    .clockFailIrq(clockFailIrq),
    .supplyWarningIrq(supplyWarningIrq),
    .wakeFromWait(wakeFromWait)
  );
  sicg_osc_model osc (.clk(clk), .run(oscRun), .spike(oscSpike), .mainOscSample(mainOscSample));

  // *****************************************
  // Helpers
  // *****************************************
  task give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask
  // Holds the request until waitrequest is sampled low, then releases it
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h000000, d};
    read <= !w;
    write <= w;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    chkb(n < 50, 1'b1, "bus answer");
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (clockSource !== s && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, clockSource}, {30'h0, s}, "clock source");
  endtask
  task do_reset(input sicg_reset_cause_type c);
    resetCause <= c;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  // *****************************************
  // Tests
  // *****************************************
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h00000000;
    byteenable = 4'h1;
    pllEnable = 1'b1;
    supplyBelowThreshold = 1'b0;
    oscRun = 1'b1;
    oscSpike = 1'b0;
    resetCause = 3'h2;
    cpuMode = 3'h0;
    do_reset(3'h2);
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chk(q, {24'h0, INTEGRITY_RESET_VALUE | 8'h10}, "status after reset");
    acc(1'b0, ADDR_GUARD_CONFIG, 8'h00);
    chk(q, {30'h0, GUARD_CONFIG_RESET_VALUE}, "config after reset");
    $display("reset test done");
    // Bit 3 is always written as zero
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].d);
      chk({30'h0, r}, {30'h0, rows[i].rs}, "write response");
      acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
      chk(q, {24'h0, rows[i].rb}, "status readback");
    end
    acc(1'b0, 4'hC, 8'h00);
    chk({30'h0, r}, 32'h2, "unmapped read");
    $display("register test done");
    cpuMode.waitMode <= 1'b1;
    supplyBelowThreshold <= 1'b1;
    repeat (4) @(posedge clk);
    chkb(supplyWarningIrq, 1'b1, "supply irq");
    chkb(wakeFromWait, 1'b1, "wake from wait");
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chk(q, 32'h64, "supply low flag");
    cpuMode.globalMask <= 1'b1;
    repeat (3) @(posedge clk);
    chkb(supplyWarningIrq, 1'b0, "masked supply irq");
    cpuMode <= 3'h0;
    acc(1'b1, ADDR_IRQ_ACK, 8'h01);
    repeat (2) @(posedge clk);
    chkb(supplyWarningIrq, 1'b0, "supply ack");
    supplyBelowThreshold <= 1'b0;
    repeat (4) @(posedge clk);
    chkb(supplyWarningIrq, 1'b1, "rising toggle irq");
    acc(1'b1, ADDR_IRQ_ACK, 8'h01);
    $display("supply test done");
    oscRun <= 1'b0;
    wait_src(CLOCK_SRC_FALLBACK);
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chkb(q[BIT_FALLBACK_ACTIVE_FLAG], 1'b1, "fallback flag");
    chkb(clockFailIrq, 1'b1, "clock fail irq");
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chkb(q[BIT_FALLBACK_ACTIVE_FLAG], 1'b1, "flag kept in fallback");
    oscRun <= 1'b1;
    wait_src(CLOCK_SRC_MAIN);
    chkb(clockFailIrq, 1'b1, "irq held");
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chkb(q[BIT_FALLBACK_ACTIVE_FLAG], 1'b1, "flag before clear");
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chkb(q[BIT_FALLBACK_ACTIVE_FLAG], 1'b0, "flag read clear");
    chkb(clockFailIrq, 1'b0, "irq dropped");
    acc(1'b1, ADDR_GUARD_CONFIG, 8'h02);
    oscRun <= 1'b0;
    repeat (30) @(posedge clk);
    chk({30'h0, clockSource}, {30'h0, CLOCK_SRC_MAIN}, "guard off no switch");
    chkb(clockFailIrq, 1'b0, "guard off irq");
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chkb(q[BIT_FALLBACK_ACTIVE_FLAG], 1'b0, "guard off flag");
    $display("clock guard test done");
    v = cpuClockFiltered;
    oscSpike <= 1'b1;
    @(posedge clk);
    oscSpike <= 1'b0;
    repeat (5) begin
      @(posedge clk);
      chkb(cpuClockFiltered, v, "spike filtered");
    end
    pllEnable <= 1'b0;
    oscSpike <= 1'b1;
    seen = 1'b0;
    @(posedge clk);
    oscSpike <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      seen = seen | (cpuClockFiltered !== v);
    end
    chkb(seen, 1'b1, "spike passes unfiltered");
    pllEnable <= 1'b1;
    oscRun <= 1'b1;
    acc(1'b1, ADDR_GUARD_CONFIG, 8'h03);
    repeat (20) @(posedge clk);
    $display("filter test done");
    cpuMode.haltMode <= 1'b1;
    repeat (4) @(posedge clk);
    chk({30'h0, clockSource}, {30'h0, CLOCK_SRC_STOPPED}, "halt stops clock");
    acc(1'b1, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    supplyBelowThreshold <= 1'b1;
    repeat (4) @(posedge clk);
    chkb(wakeFromWait, 1'b0, "no wake from halt");
    cpuMode <= 3'h0;
    wait_src(CLOCK_SRC_MAIN);
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chk(q & 32'h44, 32'h44, "config kept over halt");
    supplyBelowThreshold <= 1'b0;
    repeat (2) @(posedge clk);
    acc(1'b1, ADDR_IRQ_ACK, 8'h01);
    acc(1'b1, ADDR_GUARD_CONFIG, 8'h01);
    supplyBelowThreshold <= 1'b1;
    repeat (4) @(posedge clk);
    chkb(supplyWarningIrq, 1'b0, "no warning when detector off");
    supplyBelowThreshold <= 1'b0;
    $display("halt test done");
    foreach (rc[i]) begin
      do_reset(rc[i]);
      acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
      chk(q, {24'h0, rx[i]}, "reset source flags");
    end
    acc(1'b1, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    acc(1'b0, ADDR_INTEGRITY_CTRL_STATUS, 8'h00);
    chk(q, 32'h00, "flags cleared by zero");
    $display("reset source test done");
    give_verdict();
  end
endmodule // system_integrity_clock_guard_tb
